// >>> hdl/mfi_irq_ctrl.v
`timescale 1ns/1ps
`include "mfi_defs.vh"

module mfi_irq_ctrl (
	// clock and reset
	input  wire        CORE_CLK,
	input  wire        NRST,
	// apb slave
	input  wire        PSEL,
	input  wire        PENABLE,
	input  wire        PWRITE,
	input  wire [7:0]  PADDR,
	input  wire [31:0] PWDATA,
	output wire [31:0] PRDATA,
	output wire        PREADY,
	output wire        PSLVERR,
	// source events, one-cycle pulses on CORE_CLK, and the TMC_COUNT value
	input  wire        PWM_PERIOD_MATCH,
	input  wire        PWM_DUTY_MATCH,
	input  wire        TM_CMPA_MATCH,
	input  wire        TM_CMPP_MATCH,
	input  wire        TMC_OVERFLOW,
	input  wire        TMC_PRESET_ELAPSED,
	input  wire        TMC_CAPTURE_EDGE,
	input  wire [9:0]  TMC_COUNT,
	input  wire        NV_WRITE_DONE,
	// supply monitor level, asynchronous
	input  wire        LOW_SUPPLY,
	// processor core
	input  wire        CORE_STACK_FULL,
	input  wire        CORE_CALL_ACK,
	input  wire        CORE_RETURN_FROM_INTERRUPT_OP,
	input  wire        CORE_RET,
	output reg         CALL_REQ,
	output reg  [1:0]  CALL_VECTOR,
	output reg         PUSH_PC,
	output reg         POP_PC,
	output reg         WAKE,
	output wire        GLOBAL_IRQ_ENABLE
);

	// ****************************************
	// state codes
	// ****************************************
	localparam ST_IDLE = 2'b01;
	localparam ST_CALL = 2'b10;
	localparam [1:0] RST_CTRL = `MFI_RST_CTRL;

	// ****************************************
	// register select decode
	// ****************************************
	function [6:0] reg_sel;
		input [7:0] addr;
		begin
			case (addr)
			`MFI_OFF_CTRL:     reg_sel = 7'h01;
			`MFI_OFF_SRC_FLAG: reg_sel = 7'h02;
			`MFI_OFF_SRC_EN:   reg_sel = 7'h04;
			`MFI_OFF_GRP_EN:   reg_sel = 7'h08;
			`MFI_OFF_GRP_FLAG: reg_sel = 7'h10;
			`MFI_OFF_CAPTURE:  reg_sel = 7'h20;
			`MFI_OFF_STATUS:   reg_sel = 7'h40;
			default:           reg_sel = 7'h00;
			endcase
		end
	endfunction

	// ****************************************
	// declarations
	// ****************************************
	reg                     global_irq_enable;
	reg                     capture_mode;
	reg [`MFI_NUM_SRC-1:0]  src_flag;
	reg [`MFI_NUM_SRC-1:0]  src_enable;
	reg [`MFI_NUM_GRP-1:0]  group_irq_enable;
	reg [`MFI_NUM_GRP-1:0]  group_request_flag;
	reg [`MFI_NUM_SRC-1:0]  member_req_d;
	reg [9:0]               ten_bit_timer_capture_reg;
	reg [1:0]               state;
	reg [31:0]              rd_value;
	reg [`MFI_NUM_SRC-1:0]  next_src_flag;
	reg [`MFI_NUM_GRP-1:0]  next_group_flag;
	reg [1:0]               pick;
	reg                     next_emi;

	wire [6:0]              sel;
	wire                    addr_hit;
	wire                    wr_stb;
	wire                    low_level;
	wire                    low_rise;
	wire [`MFI_NUM_SRC-1:0] hw_set;
	wire [`MFI_NUM_SRC-1:0] member_req;
	wire [`MFI_NUM_GRP-1:0] group_set;
	wire [`MFI_NUM_GRP-1:0] eligible;
	wire                    can_take;
	wire                    wr_ctrl;
	wire                    wr_src;
	wire                    wr_en;
	wire                    wr_gen;
	wire                    wr_gflag;

	assign sel      = reg_sel(PADDR);
	assign addr_hit = |sel;
	assign wr_ctrl  = wr_stb & sel[0];
	assign wr_src   = wr_stb & sel[1];
	assign wr_en    = wr_stb & sel[2];
	assign wr_gen   = wr_stb & sel[3];
	assign wr_gflag = wr_stb & sel[4];

	assign GLOBAL_IRQ_ENABLE = global_irq_enable;

	// ****************************************
	// bus slave and supply synchroniser
	// ****************************************
	mfi_apb u_apb (
		.clk      (CORE_CLK),
		.rst_n    (NRST),
		.psel     (PSEL),
		.penable  (PENABLE),
		.pwrite   (PWRITE),
		.addr_hit (addr_hit),
		.rd_value (rd_value),
		.pready   (PREADY),
		.pslverr  (PSLVERR),
		.prdata   (PRDATA),
		.wr_stb   (wr_stb)
	);

	// monitor output is analog-derived, so it is synchronised
	mfi_sync u_low_sync (
		.clk      (CORE_CLK),
		.rst_n    (NRST),
		.async_in (LOW_SUPPLY),
		.level    (low_level),
		.rise     (low_rise)
	);

	// ****************************************
	// hardware set terms
	// ****************************************
	// pwm, timer, supply and nv event sets
	assign hw_set[`MFI_SRC_PWM_PER]  = PWM_PERIOD_MATCH;
	assign hw_set[`MFI_SRC_PWM_DUTY] = PWM_DUTY_MATCH;
	assign hw_set[`MFI_SRC_TM_A]     = TM_CMPA_MATCH;
	assign hw_set[`MFI_SRC_TM_P]     = TM_CMPP_MATCH;
	assign hw_set[`MFI_SRC_TMC_PER]  = TMC_OVERFLOW;
	assign hw_set[`MFI_SRC_TMC_CMP]  = capture_mode ? TMC_CAPTURE_EDGE
	                                                : TMC_PRESET_ELAPSED;
	assign hw_set[`MFI_SRC_LOW_SUP]  = low_rise;
	assign hw_set[`MFI_SRC_NV_DONE]  = NV_WRITE_DONE;

	// ****************************************
	// source flags
	// ****************************************
	// hold until cleared
	always @* begin
		if (wr_src) begin
			next_src_flag = PWDATA[`MFI_NUM_SRC-1:0];
		end else begin
			next_src_flag = src_flag;
		end
		// a same-cycle event beats the software clear
		next_src_flag = next_src_flag | hw_set;
	end

	always @(posedge CORE_CLK) begin
		if (!NRST) begin
			ten_bit_timer_capture_reg <= `MFI_RST_CAPTURE;
		end else if (capture_mode && TMC_CAPTURE_EDGE) begin
			ten_bit_timer_capture_reg <= TMC_COUNT;
		end
	end

	// ****************************************
	// group flags
	// ****************************************
	assign member_req = src_flag & src_enable;

	genvar g;
	generate
		for (g = 0; g < `MFI_NUM_GRP; g = g + 1) begin : grp
			assign group_set[g] =
				(member_req[2*g]   & ~member_req_d[2*g]) |
				(member_req[2*g+1] & ~member_req_d[2*g+1]);
			assign eligible[g] = group_request_flag[g] &
			                     group_irq_enable[g];
		end
	endgenerate

	assign can_take = global_irq_enable & ~CORE_STACK_FULL & (|eligible);

	// lowest group number has priority
	always @* begin
		if (eligible[0]) begin
			pick = 2'h0;
		end else if (eligible[1]) begin
			pick = 2'h1;
		end else if (eligible[2]) begin
			pick = 2'h2;
		end else begin
			pick = 2'h3;
		end
	end

	always @* begin
		if (wr_gflag) begin
			next_group_flag = PWDATA[`MFI_NUM_GRP-1:0];
		end else begin
			next_group_flag = group_request_flag;
		end
		if (state == ST_CALL && CORE_CALL_ACK) begin
			next_group_flag[CALL_VECTOR] = 1'b0;
		end
		next_group_flag = next_group_flag | group_set;
	end

	// ****************************************
	// global enable
	// ****************************************
	always @* begin
		if (wr_ctrl) begin
			next_emi = PWDATA[`MFI_CTRL_EMI];
		end else begin
			next_emi = global_irq_enable;
		end
		if (state == ST_CALL && CORE_CALL_ACK) begin
			next_emi = 1'b0;
		end
		if (CORE_RETURN_FROM_INTERRUPT_OP) begin
			next_emi = 1'b1;
		end
	end

	// ****************************************
	// register file
	// ****************************************
	always @(posedge CORE_CLK) begin
		if (!NRST) begin
			global_irq_enable  <= RST_CTRL[`MFI_CTRL_EMI];
			capture_mode       <= RST_CTRL[`MFI_CTRL_CAPMODE];
			src_flag           <= `MFI_RST_SRC;
			src_enable         <= `MFI_RST_SRC;
			group_irq_enable   <= `MFI_RST_GRP;
			group_request_flag <= `MFI_RST_GRP;
			member_req_d       <= `MFI_RST_SRC;
		end else begin
			global_irq_enable  <= next_emi;
			src_flag           <= next_src_flag;
			group_request_flag <= next_group_flag;
			member_req_d       <= member_req;
			if (wr_ctrl) begin
				capture_mode <= PWDATA[`MFI_CTRL_CAPMODE];
			end
			if (wr_en) begin
				src_enable <= PWDATA[`MFI_NUM_SRC-1:0];
			end
			if (wr_gen) begin
				group_irq_enable <= PWDATA[`MFI_NUM_GRP-1:0];
			end
		end
	end

	always @* begin
		rd_value = 32'h00000000;
		case (sel)
		7'h01: begin
			rd_value[`MFI_CTRL_EMI]     = global_irq_enable;
			rd_value[`MFI_CTRL_CAPMODE] = capture_mode;
		end
		7'h02: rd_value[`MFI_NUM_SRC-1:0] = src_flag;
		7'h04: rd_value[`MFI_NUM_SRC-1:0] = src_enable;
		7'h08: rd_value[`MFI_NUM_GRP-1:0] = group_irq_enable;
		7'h10: rd_value[`MFI_NUM_GRP-1:0] = group_request_flag;
		7'h20: rd_value[9:0] = ten_bit_timer_capture_reg;
		7'h40: begin
			rd_value[`MFI_STAT_PEND] = CALL_REQ;
			rd_value[`MFI_STAT_VEC_HI:`MFI_STAT_VEC_LO] = CALL_VECTOR;
			rd_value[`MFI_STAT_LOW] = low_level;
		end
		default: rd_value = 32'h00000000;
		endcase
	end

	// ****************************************
	// call sequencer toward the core
	// ****************************************
	always @(posedge CORE_CLK) begin
		if (!NRST) begin
			state       <= ST_IDLE;
			CALL_REQ    <= 1'b0;
			CALL_VECTOR <= `MFI_RST_VEC;
			PUSH_PC     <= 1'b0;
			POP_PC      <= 1'b0;
		end else begin
			PUSH_PC <= 1'b0;
			POP_PC  <= CORE_RETURN_FROM_INTERRUPT_OP | CORE_RET;
			case (state)
			ST_IDLE: begin
				if (can_take) begin
					CALL_VECTOR <= pick;
					CALL_REQ    <= 1'b1;
					state       <= ST_CALL;
				end
			end
			ST_CALL: begin
				if (CORE_CALL_ACK) begin
					PUSH_PC  <= 1'b1;
					CALL_REQ <= 1'b0;
					state    <= ST_IDLE;
				end else if (!(global_irq_enable && !CORE_STACK_FULL &&
				               eligible[CALL_VECTOR])) begin
					// withdrawn: software masked it or the stack filled before the core took it
					CALL_REQ <= 1'b0;
					state    <= ST_IDLE;
				end
			end
			default: begin
				CALL_REQ <= 1'b0;
				state    <= ST_IDLE;
			end
			endcase
		end
	end

	// ****************************************
	// wake-up
	// ****************************************
	// cannot run with the clock stopped; a free clock must drive it in sleep
	// any flag rise wakes
	always @(posedge CORE_CLK) begin
		if (!NRST) begin
			WAKE <= 1'b0;
		end else begin
			WAKE <= (|(next_src_flag & ~src_flag)) |
			        (|(next_group_flag & ~group_request_flag));
		end
	end

endmodule // mfi_irq_ctrl

// >>> pkg/mfi_defs.vh
`ifndef MFI_DEFS_VH
`define MFI_DEFS_VH

// ****************************************
// register byte offsets
// ****************************************
`define MFI_OFF_CTRL      8'h00
`define MFI_OFF_SRC_FLAG  8'h04
`define MFI_OFF_SRC_EN    8'h08
`define MFI_OFF_GRP_EN    8'h0C
`define MFI_OFF_GRP_FLAG  8'h10
`define MFI_OFF_CAPTURE   8'h14
`define MFI_OFF_STATUS    8'h18

// ****************************************
// field positions
// ****************************************
`define MFI_CTRL_EMI      0
`define MFI_CTRL_CAPMODE  1
`define MFI_STAT_PEND     0
`define MFI_STAT_VEC_LO   2
`define MFI_STAT_VEC_HI   3
`define MFI_STAT_LOW      4

// ****************************************
// source slots, two per group
// ****************************************
`define MFI_SRC_PWM_PER   0
`define MFI_SRC_PWM_DUTY  1
`define MFI_SRC_TM_A      2
`define MFI_SRC_TM_P      3
`define MFI_SRC_TMC_PER   4
`define MFI_SRC_TMC_CMP   5
`define MFI_SRC_LOW_SUP   6
`define MFI_SRC_NV_DONE   7
`define MFI_NUM_SRC       8
`define MFI_NUM_GRP       4

// ****************************************
// reset values
// ****************************************
`define MFI_RST_CTRL      2'h0
`define MFI_RST_SRC       8'h00
`define MFI_RST_GRP       4'h0
`define MFI_RST_CAPTURE   10'h000
`define MFI_RST_VEC       2'h0

`endif

// >>> hdl/mfi_sync.v
`timescale 1ns/1ps

// ****************************************
// two-flop synchroniser with rise detect
// ****************************************
module mfi_sync (
	// clock and reset
	input  wire clk,
	input  wire rst_n,
	// asynchronous level
	input  wire async_in,
	// synchronised results
	output wire level,
	output wire rise
);

	reg s1;
	reg s2;
	reg s3;

	// s1 feeds s2 only, never logic
	always @(posedge clk) begin
		if (!rst_n) begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end else begin
			s1 <= async_in;
			s2 <= s1;
			s3 <= s2;
		end
	end

	assign level = s2;
	assign rise  = s2 & ~s3;

endmodule // mfi_sync

// >>> hdl/mfi_apb.v
`timescale 1ns/1ps

// ****************************************
// apb slave handshake, one wait state
// ****************************************
module mfi_apb (
	// clock and reset
	input  wire        clk,
	input  wire        rst_n,
	// apb request
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	// decode and read value from the register file
	input  wire        addr_hit,
	input  wire [31:0] rd_value,
	// apb answer
	output reg         pready,
	output reg         pslverr,
	output reg  [31:0] prdata,
	// write takes effect at this edge
	output wire        wr_stb
);

	wire access_first;

	assign access_first = psel & penable & ~pready;
	assign wr_stb       = psel & penable & pready & pwrite & addr_hit;

	// read value is captured at the same edge that raises pready
	always @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready <= access_first;
			if (access_first) begin
				pslverr <= ~addr_hit;
				if (!pwrite && addr_hit) begin
					prdata <= rd_value;
				end else begin
					prdata <= 32'h00000000;
				end
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

endmodule // mfi_apb

// >>> test/mfi_irq_ctrl_props.sv
`timescale 1ns/1ps

// ****************************************
// call, return and bus checks
// ****************************************
module mfi_irq_ctrl_props (
	// clock and reset
	input wire       CORE_CLK,
	input wire       NRST,
	// apb
	input wire       PSEL,
	input wire       PENABLE,
	input wire       PREADY,
	input wire       PSLVERR,
	// core side
	input wire       CORE_STACK_FULL,
	input wire       CORE_CALL_ACK,
	input wire       CORE_RETURN_FROM_INTERRUPT_OP,
	input wire       CORE_RET,
	input wire       CALL_REQ,
	input wire [1:0] CALL_VECTOR,
	input wire       PUSH_PC,
	input wire       POP_PC,
	input wire       GLOBAL_IRQ_ENABLE
);
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!NRST);

	sequence acked_s;
		CALL_REQ && CORE_CALL_ACK;
	endsequence
	sequence ret_s;
		CORE_RETURN_FROM_INTERRUPT_OP || CORE_RET;
	endsequence
	sequence access_s;
		PSEL && PENABLE && !PREADY;
	endsequence

	call_entry_a: assert property (acked_s |=>
		PUSH_PC && !CALL_REQ && !GLOBAL_IRQ_ENABLE)
		else $error("call entry did not push and clear enable");
	push_cause_a: assert property ($rose(PUSH_PC) |->
		$past(CALL_REQ && CORE_CALL_ACK))
		else $error("push without an acknowledged call");
	call_gate_a: assert property ($rose(CALL_REQ) |->
		$past(GLOBAL_IRQ_ENABLE) && !$past(CORE_STACK_FULL))
		else $error("call raised while disabled or stack full");
	vector_hold_a: assert property (CALL_REQ && !CORE_CALL_ACK |=>
		!CALL_REQ || $stable(CALL_VECTOR))
		else $error("vector moved during a pending call");
	return_pop_a: assert property (ret_s |=> POP_PC)
		else $error("return without pc restore");
	pop_cause_a: assert property (POP_PC |->
		$past(CORE_RETURN_FROM_INTERRUPT_OP || CORE_RET))
		else $error("pc restore without return");
	return_from_interrupt_op_emi_a: assert property (CORE_RETURN_FROM_INTERRUPT_OP |=> GLOBAL_IRQ_ENABLE)
		else $error("return from interrupt left enable low");
	ret_emi_a: assert property (CORE_RET && !CORE_RETURN_FROM_INTERRUPT_OP && !PSEL &&
		!CORE_CALL_ACK |=> $stable(GLOBAL_IRQ_ENABLE))
		else $error("plain return changed global enable");
	ready_wait_a: assert property (access_s |=> PREADY)
		else $error("no answer one cycle after access");
	ready_pulse_a: assert property (PREADY |=> !PREADY)
		else $error("ready held longer than one cycle");
	error_ready_a: assert property (PSLVERR |-> PREADY)
		else $error("error flag without ready");
endmodule // mfi_irq_ctrl_props

// >>> test/mfi_core_model.sv
`timescale 1ns/1ps

// ****************************************
// processor core sequencer and stack
// ****************************************
module mfi_core_model #(
	parameter int STACK_LEVELS = 1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic call_req,
	input  wire logic push_pc,
	input  wire logic pop_pc,
	input  wire logic slow,
	input  wire logic return_from_interrupt_op_cmd,
	input  wire logic ret_cmd,
	output logic      call_ack,
	output logic      stack_full,
	output logic      return_from_interrupt_op,
	output logic      ret
);
	int depth;
	int wait_cnt;

	assign stack_full = depth >= STACK_LEVELS;

	always @(posedge clk) begin
		if (!rst_n) begin
			depth <= 0;
			wait_cnt <= 0;
			call_ack <= 1'h0;
			return_from_interrupt_op <= 1'h0;
			ret <= 1'h0;
		end else begin
			// push and pop pc only, no handler calls
			depth <= depth + int'(push_pc) - int'(pop_pc);
			call_ack <= 1'h0;
			// slow core stalls the ack, never acks without request
			if (call_req && !call_ack) begin
				if (wait_cnt >= (slow ? 5 : 0)) begin
					call_ack <= 1'h1;
					wait_cnt <= 0;
				end else begin
					wait_cnt <= wait_cnt + 1;
				end
			end else begin
				wait_cnt <= 0;
			end
			return_from_interrupt_op <= return_from_interrupt_op_cmd;
			ret <= ret_cmd;
		end
	end
endmodule // mfi_core_model

// >>> test/tb.sv
`timescale 1ns/1ps
`include "mfi_defs.vh"

`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin \
	n_errors++; \
	$display("unexpected at %0t: got %h want %h", $time, got, exp); \
	end end

module tb;
	// ****************************************
	// stimulus and observation
	// ****************************************
	logic        CORE_CLK = 0, NRST = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
	logic [7:0]  PADDR = 0, ev = 0;
	logic [31:0] PWDATA = 0, PRDATA, q;
	logic [9:0]  TMC_COUNT = 0;
	logic        cap_edge = 0, slow = 0, return_from_interrupt_op_cmd = 0, ret_cmd = 0, e;
	logic        PREADY, PSLVERR, CORE_STACK_FULL, CORE_CALL_ACK, CORE_RETURN_FROM_INTERRUPT_OP;
	logic        CORE_RET, CALL_REQ, PUSH_PC, POP_PC, WAKE, GLOBAL_IRQ_ENABLE;
	logic [1:0]  CALL_VECTOR, last_vec;
	int          n_errors = 0, comparisons = 0, wakes = 0, pushes = 0, p, w;

	mfi_irq_ctrl u_dut (.CORE_CLK, .NRST, .PSEL, .PENABLE, .PWRITE, .PADDR,
		.PWDATA, .PRDATA, .PREADY, .PSLVERR, .PWM_PERIOD_MATCH(ev[0]),
		.PWM_DUTY_MATCH(ev[1]), .TM_CMPA_MATCH(ev[2]), .TM_CMPP_MATCH(ev[3]),
		.TMC_OVERFLOW(ev[4]), .TMC_PRESET_ELAPSED(ev[5]),
		.TMC_CAPTURE_EDGE(cap_edge), .TMC_COUNT, .NV_WRITE_DONE(ev[7]),
		.LOW_SUPPLY(ev[6]), .CORE_STACK_FULL, .CORE_CALL_ACK, .CORE_RETURN_FROM_INTERRUPT_OP,
		.CORE_RET, .CALL_REQ, .CALL_VECTOR, .PUSH_PC, .POP_PC, .WAKE,
		.GLOBAL_IRQ_ENABLE);

	mfi_core_model #(.STACK_LEVELS(1)) u_core (.clk(CORE_CLK), .rst_n(NRST),
		.call_req(CALL_REQ), .push_pc(PUSH_PC), .pop_pc(POP_PC), .slow(slow),
		.return_from_interrupt_op_cmd(return_from_interrupt_op_cmd), .ret_cmd(ret_cmd), .call_ack(CORE_CALL_ACK),
		.stack_full(CORE_STACK_FULL), .return_from_interrupt_op(CORE_RETURN_FROM_INTERRUPT_OP), .ret(CORE_RET));

	initial forever #4 CORE_CLK = ~CORE_CLK;

	always @(posedge CORE_CLK) begin
		if (WAKE === 1'h1) wakes++;
		if (PUSH_PC === 1'h1) pushes++;
		if (CALL_REQ === 1'h1 && CORE_CALL_ACK === 1'h1) last_vec <= CALL_VECTOR;
	end

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge CORE_CLK);
		PSEL <= 1'h1;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge CORE_CLK);
		PENABLE <= 1'h1;
		// wait for the answer; only the watchdog ends a hang
		do @(posedge CORE_CLK); while (PREADY !== 1'h1);
		q = PRDATA;
		e = PSLVERR;
		PSEL <= 1'h0;
		PENABLE <= 1'h0;
	endtask

	task automatic chk_rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'h0, a, 32'h0);
		`CHK(q, x)
	endtask

	task automatic fire(input int i);
		@(posedge CORE_CLK);
		ev[i] <= 1'h1;
		@(posedge CORE_CLK);
		// supply level stays low-supply until the test lowers it
		if (i != 6) ev[i] <= 1'h0;
		repeat (5) @(posedge CORE_CLK);
	endtask

	task automatic wait_push(input int n);
		for (int k = 0; k < 40 && pushes < n; k++) @(posedge CORE_CLK);
	endtask

	task automatic do_ret(input logic full);
		@(posedge CORE_CLK);
		if (full) return_from_interrupt_op_cmd <= 1'h1; else ret_cmd <= 1'h1;
		@(posedge CORE_CLK);
		return_from_interrupt_op_cmd <= 1'h0;
		ret_cmd <= 1'h0;
		repeat (3) @(posedge CORE_CLK);
	endtask

	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge CORE_CLK);
		n_errors++;
		wrap_up;
	end

	initial begin
		repeat (6) @(posedge CORE_CLK);
		NRST <= 1'h1;
		for (int a = 0; a <= 'h18; a += 4) chk_rd(8'(a), 32'h0);
		apb(1'h0, 8'h40, 32'h0);
		`CHK({e, q}, 33'h1_0000_0000)
		apb(1'h1, `MFI_OFF_GRP_FLAG, 32'hF);
		chk_rd(`MFI_OFF_GRP_FLAG, 32'hF);
		apb(1'h1, `MFI_OFF_GRP_FLAG, 32'h0);
		$display("test reset and map done");
		// every source sets its own flag and wakes, all enables off
		for (int i = 0; i < 8; i++) begin
			w = wakes;
			fire(i);
			`CHK(wakes, w + 1)
			fire(i);
			`CHK(wakes, w + 1)
			chk_rd(`MFI_OFF_SRC_FLAG,
			       (32'h1 << (i + 1)) - 32'h1);
			chk_rd(`MFI_OFF_GRP_FLAG, 32'h0);
		end
		`CHK(pushes, 0)
		chk_rd(`MFI_OFF_STATUS, 32'h10);
		ev[6] <= 1'h0;
		apb(1'h1, `MFI_OFF_SRC_FLAG, 32'h0);
		$display("test source flags done");
		apb(1'h1, `MFI_OFF_CTRL, 32'h2);
		TMC_COUNT <= 10'h2A5;
		fire(5);
		`CHK(wakes, w + 1)
		cap_edge <= 1'h1;
		@(posedge CORE_CLK);
		cap_edge <= 1'h0;
		repeat (3) @(posedge CORE_CLK);
		chk_rd(`MFI_OFF_CAPTURE, 32'h2A5);
		chk_rd(`MFI_OFF_SRC_FLAG, 32'h20);
		apb(1'h1, `MFI_OFF_SRC_FLAG, 32'h0);
		$display("test capture done");
		apb(1'h1, `MFI_OFF_SRC_EN, 32'hFF);
		apb(1'h1, `MFI_OFF_GRP_EN, 32'hF);
		for (int g = 0; g < 4; g++) begin
			p = pushes;
			slow <= g[0];
			apb(1'h1, `MFI_OFF_CTRL, 32'h1);
			fire(2 * g + g[0]);
			wait_push(p + 1);
			`CHK(pushes, p + 1)
			`CHK(last_vec, 2'(g))
			chk_rd(`MFI_OFF_CTRL, 32'h0);
			chk_rd(`MFI_OFF_GRP_FLAG, 32'h0);
			chk_rd(`MFI_OFF_SRC_FLAG, 32'h1 << (2 * g + g[0]));
			apb(1'h1, `MFI_OFF_SRC_FLAG, 32'h0);
			do_ret(!g[0]);
			chk_rd(`MFI_OFF_CTRL, {31'h0, !g[0]});
		end
		ev[6] <= 1'h0;
		$display("test group calls done");
		p = pushes;
		apb(1'h1, `MFI_OFF_CTRL, 32'h1);
		fire(0);
		wait_push(p + 1);
		apb(1'h1, `MFI_OFF_SRC_FLAG, 32'h0);
		apb(1'h1, `MFI_OFF_CTRL, 32'h1);
		fire(2);
		repeat (20) @(posedge CORE_CLK);
		`CHK(pushes, p + 1)
		chk_rd(`MFI_OFF_GRP_FLAG, 32'h2);
		do_ret(1'h0);
		wait_push(p + 2);
		`CHK(pushes, p + 2)
		`CHK(last_vec, 2'h1)
		do_ret(1'h1);
		$display("test stack full done");
		wrap_up;
	end
endmodule // tb

bind mfi_irq_ctrl mfi_irq_ctrl_props u_props (.CORE_CLK, .NRST, .PSEL,
	.PENABLE, .PREADY, .PSLVERR, .CORE_STACK_FULL, .CORE_CALL_ACK,
	.CORE_RETURN_FROM_INTERRUPT_OP, .CORE_RET, .CALL_REQ, .CALL_VECTOR, .PUSH_PC, .POP_PC,
	.GLOBAL_IRQ_ENABLE);
